// *** rtl/cprm_pkg.sv ***
// Shared constants and types for the clock path, reset and multiplier control block.
// Assumes a single 125 MHz register clock that also stands in for the input clock rate.
package cprm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned POR_WAIT_US = 100;
  localparam int unsigned LONG_CAL_TIME_US = 5000;
  localparam int unsigned LONG_CAL_CYCLES = LONG_CAL_TIME_US * CLK_MHZ;
  localparam int unsigned SHORT_CAL_TIME_US = 500;
  localparam int unsigned SHORT_CAL_CYCLES = SHORT_CAL_TIME_US * CLK_MHZ;
  localparam int unsigned WDOG_W = 20;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_SEQ = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned CTRL_RESET_BIT = 0;
  localparam int unsigned CHAN_PATH_LSB = 0;
  localparam int unsigned CHAN_BUF_LSB = 4;
  localparam int unsigned CHAN_LVL_LSB = 8;
  localparam int unsigned SEQ_PRE_LSB = 0;
  localparam int unsigned SEQ_DIV_LSB = 8;
  localparam int unsigned PRE_W = 3;
  localparam int unsigned SDIV_W = 8;
  localparam int unsigned TEMP_W = 10;
  localparam int unsigned STAT_TEMP_LSB = 0;
  localparam int unsigned STAT_LOCK_BIT = 16;
  localparam int unsigned STAT_BUSY_BIT = 17;
  localparam int unsigned STAT_SEQEN_BIT = 18;
  localparam logic [31:0] CHAN_RST = 32'h000f_ffff;
  localparam logic [31:0] MODE_RST = 32'h0000_0024;
  localparam logic [31:0] SEQ_RST = 32'h0000_0801;
  localparam int unsigned MODE_W = 9;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_BUFFER = 2'h0;
  localparam logic [1:0] SRC_DIVIDE = 2'h1;
  localparam logic [1:0] SRC_MULTIPLY = 2'h2;
  localparam logic [2:0] DIV_BY2 = 3'h1;
  localparam logic [2:0] DIV_BY3 = 3'h2;
  localparam logic [2:0] DIV_BY4 = 3'h3;
  localparam logic [2:0] DIV_BY5 = 3'h4;
  localparam logic [2:0] DIV_BY7 = 3'h6;
  localparam logic [1:0] MULT_X2 = 2'h0;
  localparam logic [1:0] MULT_X3 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic div_reset;
    logic [1:0] multiply_ratio_field;
    logic sequencer_clock_enable;
    logic [2:0] divide_code;
    logic [1:0] output_source_select;
  } cprm_mode_t;

  typedef struct packed {
    logic [NUM_CH-1:0] path_on;
    logic [NUM_CH-1:0] buffer_on;
    logic [NUM_CH-1:0][LVL_W-1:0] level;
  } cprm_chan_t;

  typedef enum logic {CAL_IDLE, CAL_RUN} cprm_cal_state_t;

endpackage

// *** rtl/cprm_seqclk.sv ***
// Sequencer clock tick generator: one pulse every prescale x divide cycles.
// Assumes enable and clear come from logic on the same clock.
`timescale 1ns/10ps
module cprm_seqclk
  import cprm_pkg::*;
#(
  parameter int unsigned PW = PRE_W,
  parameter int unsigned DW = SDIV_W
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic clear, // Soft reset pulse
  input wire logic enable, // Sequencer clock enable
  input wire logic [PW-1:0] prescale, // Prescale value
  input wire logic [DW-1:0] divide, // Divide value
  output logic tick // One cycle per sequencer period
);

  logic [PW+DW-1:0] count_reg;
  logic [PW+DW-1:0] count_next;
  logic [PW+DW-1:0] period;

  always_comb
  begin
    period = (PW+DW)'(prescale * divide);
    tick = 1'b0;
    count_next = count_reg;
    if (!enable)
    begin
      count_next = '0;
    end
    else if (count_reg + (PW+DW)'(1) >= period)
    begin
      // A zero product ticks every cycle rather than stalling
      tick = 1'b1;
      count_next = '0;
    end
    else
    begin
      count_next = count_reg + (PW+DW)'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule

// *** rtl/cprm_cal.sv ***
// Multiplier calibration sequencer with watchdog restart.
// Assumes the analog calibration done level is already synchronised.
`timescale 1ns/10ps
module cprm_cal
  import cprm_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CAL_CYCLES,
  parameter int unsigned SHORT_CYCLES = SHORT_CAL_CYCLES
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic clear, // Soft reset pulse
  input wire logic start, // Calibration request pulse
  input wire logic mode_change, // Source select changed
  input wire logic seq_enable, // Sequencer clock running
  input wire logic cal_done, // Analog calibration finished
  output logic vco_cal_start, // Kick to analog calibration
  output logic busy // Calibration in progress
);

  localparam logic [WDOG_W-1:0] LONG_LIM = WDOG_W'(LONG_CYCLES - 1);
  localparam logic [WDOG_W-1:0] SHORT_LIM = WDOG_W'(SHORT_CYCLES - 1);

  cprm_cal_state_t state_reg;
  cprm_cal_state_t state_next;
  logic [WDOG_W-1:0] wdog_reg;
  logic [WDOG_W-1:0] wdog_next;
  logic long_reg;
  logic long_next;
  logic kick_reg;
  logic kick_next;
  logic armed_reg;
  logic armed_next;

  always_comb
  begin
    state_next = state_reg;
    wdog_next = wdog_reg;
    kick_next = 1'b0;
    long_next = long_reg;
    unique case (state_reg)
      CAL_IDLE:
      begin
        if (start)
        begin
          state_next = CAL_RUN;
          wdog_next = '0;
          kick_next = 1'b1;
        end
      end
      CAL_RUN:
      begin
        if (start)
        begin
          wdog_next = '0;
          kick_next = 1'b1;
        end
        else if (cal_done && armed_reg)
        begin
          state_next = CAL_IDLE;
          long_next = 1'b0;
        end
        else if (wdog_reg == (long_reg ? LONG_LIM : SHORT_LIM))
        begin
          // Watchdog ran out: begin the calibration again
          wdog_next = '0;
          kick_next = 1'b1;
        end
        else if (seq_enable)
        begin
          wdog_next = wdog_reg + WDOG_W'(1);
        end
      end
    endcase
    // A mode change in the same cycle as completion keeps the long window
    if (mode_change)
      long_next = 1'b1;
    // Synchroniser still shows the previous done level for a few cycles after a kick
    armed_next = (armed_reg || !cal_done) && !kick_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      state_reg <= CAL_IDLE;
      wdog_reg <= '0;
      long_reg <= 1'b1;
      kick_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wdog_reg <= wdog_next;
      long_reg <= long_next;
      kick_reg <= kick_next;
      armed_reg <= armed_next;
    end
  end

  assign vco_cal_start = kick_reg;
  assign busy = (state_reg == CAL_RUN);

endmodule

// *** rtl/cprm_top.sv ***
// Clock path, reset and multiplier control: AXI4-Lite registers driving the
// output channel enables, source select, divider, multiplier calibration and lock.
// Assumes analog status pins are asynchronous and pass a two-stage synchroniser.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module cprm_top
  import cprm_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CAL_CYCLES,
  parameter int unsigned SHORT_CYCLES = SHORT_CAL_CYCLES
)
(
  input wire logic aclk, // Clock, 125 MHz
  input wire logic aresetn, // Sync reset, low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic input_clock_present, // Input clock detected, async
  input wire logic pll_lock_raw, // Multiplier PLL lock, async
  input wire logic vco_cal_done_raw, // Analog calibration done, async
  input wire logic [TEMP_W-1:0] temp_code_raw, // Temperature code, async
  output cprm_chan_t chan_ctrl, // Per-channel power and level
  output cprm_mode_t mode_ctrl, // Source, divide, multiply controls
  output logic divider_reset, // Main divider resync
  output logic sequencer_tick, // Sequencer clock pulse
  output logic vco_cal_start, // Calibration kick
  output logic cal_busy, // Calibration in progress
  output logic readback_output_pin // Lock state
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Temperature bits cross independently; a read may catch a mixed code
  localparam int unsigned SYNC_W = TEMP_W + 3;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic clk_ok;
  logic lock_sync;
  logic cal_done_sync;
  logic [TEMP_W-1:0] temp_sync;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {input_clock_present, pll_lock_raw, vco_cal_done_raw, temp_code_raw};
      sync2_reg <= sync1_reg;
    end
  end

  assign {clk_ok, lock_sync, cal_done_sync, temp_sync} = sync2_reg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic reset_bit_reg, reset_bit_next;
  logic [31:0] chan_reg, chan_next;
  cprm_mode_t mode_reg, mode_next;
  logic [31:0] seq_reg, seq_next;
  logic lock_reg, lock_next;
  logic soft_reset;
  logic cal_start;
  logic mode_change;
  logic [31:0] merged;
  logic [31:0] status_word;
  cprm_mode_t wmode;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  always_comb
  begin
    status_word = '0;
    status_word[STAT_TEMP_LSB +: TEMP_W] = temp_sync;
    status_word[STAT_LOCK_BIT] = lock_reg;
    status_word[STAT_BUSY_BIT] = cal_busy;
    status_word[STAT_SEQEN_BIT] = mode_reg.sequencer_clock_enable;
  end

  // ----------------------------------------------------------------
  // Bus and register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    reset_bit_next = reset_bit_reg;
    chan_next = chan_reg;
    mode_next = mode_reg;
    seq_next = seq_reg;
    soft_reset = 1'b0;
    cal_start = 1'b0;
    merged = '0;
    wmode = mode_reg;

    if (awvalid && awready)
    begin
      aw_held_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready)
    begin
      w_held_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    if (bvalid_reg && bready)
      bvalid_next = 1'b0;

    if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      unique case ({waddr_reg[ADDR_W-1:2], 2'b00})
        OFS_CTRL:
        begin
          merged = merge_bytes({31'h0000_0000, reset_bit_reg}, wdata_reg, wstrb_reg);
          reset_bit_next = merged[CTRL_RESET_BIT];
          // Reset finishes in this one cycle, well ahead of any next write
          soft_reset = merged[CTRL_RESET_BIT];
          cal_start = clk_ok && !merged[CTRL_RESET_BIT];
        end
        OFS_CHAN:
        begin
          reset_bit_next = 1'b0;
          chan_next = merge_bytes(chan_reg, wdata_reg, wstrb_reg);
        end
        OFS_MODE:
        begin
          reset_bit_next = 1'b0;
          merged = merge_bytes(32'(mode_reg), wdata_reg, wstrb_reg);
          wmode = cprm_mode_t'(merged[MODE_W-1:0]);
          mode_next = wmode;
          // Reserved codes are refused and the previous setting stays
          if (wmode.output_source_select == 2'h3)
            mode_next.output_source_select = mode_reg.output_source_select;
          if (wmode.divide_code == 3'h0 || wmode.divide_code == 3'h5 || wmode.divide_code == 3'h7)
            mode_next.divide_code = mode_reg.divide_code;
          if (wmode.multiply_ratio_field == 2'h3)
            mode_next.multiply_ratio_field = mode_reg.multiply_ratio_field;
        end
        OFS_SEQ:
        begin
          reset_bit_next = 1'b0;
          seq_next = merge_bytes(seq_reg, wdata_reg, wstrb_reg);
        end
        OFS_STATUS:
        begin
          reset_bit_next = 1'b0;
        end
        default:
        begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end

    if (soft_reset)
    begin
      chan_next = CHAN_RST;
      mode_next = cprm_mode_t'(MODE_RST[MODE_W-1:0]);
      seq_next = SEQ_RST;
    end

    if (rvalid_reg && rready)
      rvalid_next = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case ({araddr[ADDR_W-1:2], 2'b00})
        OFS_CTRL: rdata_next = {31'h0000_0000, reset_bit_reg};
        OFS_CHAN: rdata_next = chan_reg;
        OFS_MODE: rdata_next = 32'(mode_reg);
        OFS_SEQ: rdata_next = seq_reg;
        OFS_STATUS: rdata_next = status_word;
        default:
        begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  assign mode_change = (mode_next.output_source_select != mode_reg.output_source_select);

  // Lock is only trusted while the sequencer clock runs
  always_comb
  begin
    lock_next = lock_reg;
    if (soft_reset || !mode_reg.sequencer_clock_enable || mode_reg.output_source_select != SRC_MULTIPLY)
      lock_next = 1'b0;
    else if (sequencer_tick)
      lock_next = lock_sync;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      reset_bit_reg <= 1'b0;
      chan_reg <= CHAN_RST;
      mode_reg <= cprm_mode_t'(MODE_RST[MODE_W-1:0]);
      seq_reg <= SEQ_RST;
      lock_reg <= 1'b0;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      reset_bit_reg <= reset_bit_next;
      chan_reg <= chan_next;
      mode_reg <= mode_next;
      seq_reg <= seq_next;
      lock_reg <= lock_next;
    end
  end

  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Channel power gating
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_chan
    always_comb
    begin
      chan_ctrl.path_on[c] = chan_reg[CHAN_PATH_LSB + c];
      chan_ctrl.buffer_on[c] = chan_reg[CHAN_PATH_LSB + c] && chan_reg[CHAN_BUF_LSB + c];
      chan_ctrl.level[c] = chan_ctrl.buffer_on[c] ? chan_reg[CHAN_LVL_LSB + LVL_W*c +: LVL_W] : '0;
    end
  end

  assign mode_ctrl = mode_reg;
  // Divider held in reset during a soft reset too
  assign divider_reset = mode_reg.div_reset || reset_bit_reg;

  // ----------------------------------------------------------------
  // Sequencer clock and calibration
  // ----------------------------------------------------------------
  cprm_seqclk u_seqclk (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_reset),
    .enable(mode_reg.sequencer_clock_enable),
    .prescale(seq_reg[SEQ_PRE_LSB +: PRE_W]),
    .divide(seq_reg[SEQ_DIV_LSB +: SDIV_W]),
    .tick(sequencer_tick)
  );

  cprm_cal #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_cal (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_reset),
    .start(cal_start && mode_reg.output_source_select == SRC_MULTIPLY),
    .mode_change(mode_change),
    .seq_enable(mode_reg.sequencer_clock_enable),
    .cal_done(cal_done_sync),
    .vco_cal_start(vco_cal_start),
    .busy(cal_busy)
  );

  // No serial readback on this bus: the pin carries lock only, low otherwise
  assign readback_output_pin = lock_reg;

endmodule

// *** dv/cprm_analog_model.sv ***
// Behavioural analog side: calibration done and lock after a set delay.
// Assumes kicks arrive from the block on aclk; a long delay starves the watchdog.
`timescale 1ns/10ps
module cprm_analog_model
(
  input wire logic aclk, // Clock
  input wire logic vco_cal_start, // Calibration kick
  input wire logic [15:0] cal_delay, // Cycles until done
  output logic vco_cal_done_raw, // Done level
  output logic pll_lock_raw // Lock level
);
  logic [15:0] cnt = '0;
  initial vco_cal_done_raw = 1'b0;
  initial pll_lock_raw = 1'b0;
  // No lock before the first kick
  always @(posedge aclk)
  begin
    if (vco_cal_start)
    begin
      cnt <= cal_delay;
      vco_cal_done_raw <= 1'b0;
      pll_lock_raw <= 1'b0;
    end
    else if (cnt > 16'h0001) cnt <= cnt - 16'h0001;
    else if (cnt == 16'h0001)
    begin
      cnt <= '0;
      vco_cal_done_raw <= 1'b1;
      pll_lock_raw <= 1'b1;
    end
  end
endmodule

// *** dv/cprm_top_props.sv ***
// Checker for the control block outputs.
// Assumes one clock domain; bound to every top instance.
`timescale 1ns/10ps
module cprm_top_props
  import cprm_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CAL_CYCLES
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [1:0] bresp, // Write response
  input wire logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [31:0] rdata, // Read data
  input wire cprm_chan_t chan_ctrl, // Channel controls
  input wire cprm_mode_t mode_ctrl, // Mode controls
  input wire logic sequencer_tick, // Sequencer pulse
  input wire logic vco_cal_start, // Calibration kick
  input wire logic cal_busy, // Calibration busy
  input wire logic readback_output_pin // Lock pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned wd_cnt_reg;
  int unsigned wd_cnt_next;
  // Pauses with the sequencer clock, as the watchdog does
  always_comb wd_cnt_next = (vco_cal_start || !cal_busy) ? 0 : wd_cnt_reg + mode_ctrl.sequencer_clock_enable;
  always_ff @(posedge aclk) wd_cnt_reg <= aresetn ? wd_cnt_next : 0;
  sequence b_wait;
    bvalid && !bready;
  endsequence
  sequence r_wait;
    rvalid && !rready;
  endsequence
  sequence seq_off;
    !mode_ctrl.sequencer_clock_enable [*2];
  endsequence
  b_hold_a: assert property (b_wait |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  r_hold_a: assert property (r_wait |=> rvalid && $stable(rdata)) else $error("rdata dropped");
  path_gate_a: assert property ((chan_ctrl.buffer_on & ~chan_ctrl.path_on) == '0) else $error("buffer on");
  lvl_gate_a: assert property (!chan_ctrl.buffer_on[0] |-> chan_ctrl.level[0] == '0) else $error("level");
  src_code_a: assert property (mode_ctrl.output_source_select != 2'h3) else $error("bad source");
  div_code_a: assert property (!(mode_ctrl.divide_code inside {3'h0, 3'h5, 3'h7})) else $error("bad div");
  mult_code_a: assert property (mode_ctrl.multiply_ratio_field != 2'h3) else $error("bad mult");
  kick_busy_a: assert property (vco_cal_start |-> cal_busy) else $error("kick not busy");
  tick_gate_a: assert property (seq_off |-> !sequencer_tick) else $error("tick while off");
  lock_gate_a: assert property (seq_off |-> !readback_output_pin) else $error("lock while off");
  wdog_lim_a: assert property (wd_cnt_reg < LONG_CYCLES + 2) else $error("no restart");
endmodule
bind cprm_top cprm_top_props #(.LONG_CYCLES(LONG_CYCLES)) u_props (.aclk, .aresetn, .bvalid, .bready, .bresp,
  .rvalid, .rready, .rdata, .chan_ctrl, .mode_ctrl, .sequencer_tick, .vco_cal_start, .cal_busy, .readback_output_pin);

// *** dv/cprm_top_test.sv ***
// Self-checking bench: AXI4-Lite master, analog model, one task per scenario.
// Assumes shortened calibration counts of 40 and 10 cycles.
`timescale 1ns/10ps
module cprm_top_test
  import cprm_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, clk_ok = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [15:0] cal_delay = 16'h0005;
  logic awready, wready, bvalid, arready, rvalid, divider_reset, tick, kick, cal_busy, pin, done_raw, lock_raw;
  logic [1:0] bresp, rresp, rsp;
  cprm_chan_t chan_ctrl;
  cprm_mode_t mode_ctrl;
  int err_count = 0, checks = 0, kicks = 0, ticks = 0, k, t;
  cprm_top #(.LONG_CYCLES(40), .SHORT_CYCLES(10)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .input_clock_present(clk_ok), .pll_lock_raw(lock_raw), .vco_cal_done_raw(done_raw),
    .temp_code_raw(10'h21a), .chan_ctrl, .mode_ctrl, .divider_reset, .sequencer_tick(tick), .vco_cal_start(kick),
    .cal_busy, .readback_output_pin(pin));
  cprm_analog_model u_ana (.aclk, .vco_cal_start(kick), .cal_delay, .vco_cal_done_raw(done_raw),
    .pll_lock_raw(lock_raw));
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    kicks <= kicks + kick;
    ticks <= ticks + tick;
  end
  task automatic test_done();
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      err_count++;
      $display("Error %0t: timeout", $time);
      test_done();
    end
  endtask
  // Address and data offered together; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    rsp = bresp;
    tmo(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    tmo(n);
  endtask
  task automatic t_reset();
    rdr(OFS_CHAN); chk(rd, CHAN_RST);
    rdr(OFS_MODE); chk(rd, MODE_RST);
    rdr(OFS_SEQ); chk(rd, SEQ_RST);
    rdr(OFS_STATUS); chk(rd[STAT_SEQEN_BIT], 1'b1);
    chk(rd[TEMP_W-1:0], 10'h21a);
    rdr(8'h14); chk(rsp, RESP_SLVERR);
    wr(8'h14, '0); chk(rsp, RESP_SLVERR);
  endtask
  task automatic t_chan();
    wr(OFS_CHAN, 32'h000e_e9be); chk(chan_ctrl, {4'he, 4'ha, 12'he28});
  endtask
  // Every code of source, divide and multiply; reserved ones keep the old value
  task automatic t_mode();
    logic [1:0] s;
    logic [2:0] d;
    s = 2'h0;
    d = 3'h1;
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_MODE, {23'h0, 1'b0, i[1:0], 1'b1, i[2:0], i[1:0]});
      if (i[1:0] != 2'h3) s = i[1:0];
      if (!(i inside {0, 5, 7})) d = i[2:0];
      chk(mode_ctrl, {1'b0, s, 1'b1, d, s});
    end
    // Divider resync after an input frequency change: raise then drop
    wr(OFS_MODE, {23'h0, 1'b1, s, 1'b1, d, s}); chk(divider_reset, 1'b1);
    wr(OFS_MODE, {23'h0, 1'b0, s, 1'b1, d, s}); chk(divider_reset, 1'b0);
  endtask
  task automatic t_noclk();
    clk_ok <= 1'b0;
    wr(OFS_MODE, 32'h0000_009a);
    k = kicks;
    t = ticks;
    wr(OFS_CTRL, '0);
    repeat (20) @(posedge aclk);
    chk(kicks - k, 0);
    chk(ticks - t, 0);
    chk(pin, 1'b0);
    wr(OFS_MODE, 32'h0000_00ba);
    clk_ok <= 1'b1;
  endtask
  task automatic t_cal();
    int n;
    n = 0;
    k = kicks;
    wr(OFS_CTRL, '0);
    while (pin !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    chk(kicks - k, 1);
    chk(cal_busy, 1'b0);
    rdr(OFS_STATUS); chk(rd[STAT_LOCK_BIT], 1'b1);
    // Default prescale 1 and divide 8: one tick per 8 cycles, under 30 MHz
    t = ticks;
    repeat (80) @(posedge aclk);
    chk(ticks - t, 10);
  endtask
  task automatic t_wdog();
    cal_delay <= 16'd500;
    k = kicks;
    wr(OFS_CTRL, '0);
    repeat (100) @(posedge aclk);
    chk(kicks - k > 2, 1'b1);
    chk(cal_busy, 1'b1);
  endtask
  task automatic t_sreset();
    wr(OFS_CTRL, 32'h1); chk(divider_reset, 1'b1);
    chk(cal_busy, 1'b0);
    rdr(OFS_MODE); chk(rd, MODE_RST);
    rdr(OFS_CTRL); chk(rd[0], 1'b1);
    wr(OFS_CHAN, CHAN_RST); chk(divider_reset, 1'b0);
    rdr(OFS_CTRL); chk(rd[0], 1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_chan();
    t_mode();
    t_noclk();
    t_cal();
    t_wdog();
    t_sreset();
    test_done();
  end
endmodule
